// ==== inc/scl_pkg.sv ====
// Shared constants and types of the synthesizer configuration loader.
`default_nettype none
package scl_pkg;

    // ==========================================================
    // Field widths
    localparam int LOOP_W = 9;
    localparam int POST_W = 2;
    localparam int DIAG_W = 3;
    localparam int CNT_W = 3;

    // ==========================================================
    // Carriers
    // Frame order, most significant first: diag pick, post code, loop
    typedef struct packed {
        logic [DIAG_W-1:0] diag;
        logic [POST_W-1:0] post;
        logic [LOOP_W-1:0] loop;
    } scl_cfg_s;

    localparam int FRAME_W = $bits(scl_cfg_s);

    // All pin levels that cross into the clock domain
    typedef struct packed {
        logic s_clk;
        logic s_data;
        logic s_load;
        logic p_load;
        logic [LOOP_W-1:0] loop;
        logic [POST_W-1:0] post;
        logic oe;
        logic ref_sel;
        logic ext_ref;
        logic xtal;
        logic osc;
    } scl_pins_s;

    localparam int PINS_W = $bits(scl_pins_s);

    // ==========================================================
    // Output divide codes
    localparam logic [POST_W-1:0] POST_DIV2 = 2'h0;
    localparam logic [POST_W-1:0] POST_DIV4 = 2'h1;
    localparam logic [POST_W-1:0] POST_DIV8 = 2'h2;
    localparam logic [POST_W-1:0] POST_DIV1 = 2'h3;

    // Oscillator rising edges per half period of the divided output
    localparam logic [CNT_W-1:0] HALF_DIV2 = 3'h1;
    localparam logic [CNT_W-1:0] HALF_DIV4 = 3'h2;
    localparam logic [CNT_W-1:0] HALF_DIV8 = 3'h4;
    localparam logic [CNT_W-1:0] HALF_NONE = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

    // ==========================================================
    // Diagnostic output selections
    localparam logic [DIAG_W-1:0] DIAG_REF = 3'h0;
    localparam logic [DIAG_W-1:0] DIAG_OSC = 3'h1;
    localparam logic [DIAG_W-1:0] DIAG_DIVOUT = 3'h2;
    localparam logic [DIAG_W-1:0] DIAG_SHIFT_MSB = 3'h3;
    localparam logic [DIAG_W-1:0] DIAG_LOW = 3'h4;
    localparam logic [DIAG_W-1:0] DIAG_HIGH = 3'h5;
    localparam logic [DIAG_W-1:0] DIAG_EXTREF = 3'h6;
    localparam logic [DIAG_W-1:0] DIAG_XTAL = 3'h7;

    // ==========================================================
    // Reset and open-pin values
    localparam logic [LOOP_W-1:0] LOOP_RST = 9'h1FF;
    localparam logic [POST_W-1:0] POST_RST = 2'h3;
    localparam logic [DIAG_W-1:0] DIAG_RST = 3'h0;
    localparam logic [FRAME_W-1:0] FRAME_RST = 14'h0000;
    localparam logic PULL_DOWN = 1'b0;
    localparam logic PULL_UP = 1'b1;
    localparam logic [LOOP_W-1:0] LOOP_OPEN = 9'h1FF;
    localparam logic [POST_W-1:0] POST_OPEN = 2'h3;
    // Pin bundle at its open levels: pulls applied, both strobes closed
    localparam logic [PINS_W-1:0] PINS_RST = 20'h1FFF8;

    // Which path last opened the latches
    typedef enum logic {
        SCL_SRC_SERIAL,
        SCL_SRC_PARALLEL
    } scl_src_e;

endpackage : scl_pkg
`default_nettype wire

// ==== rtl/scl_sync.sv ====
// Two-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ns
`default_nettype none
module scl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ==========================================================
    // Both stages; only the second stage leaves the module
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : scl_sync
`default_nettype wire

// ==== rtl/scl_config_loader.sv ====
// Configuration loader and output divider of the frequency synthesizer.
// Notes on behaviour
// [R1] Code 00,01,10,11 divides by 2,4,8,1
// [R2] Output is oscillator divided by selected ratio
// [R3] Host keeps oscillator within 400-800 MHz
// [R4] High select uses crystal, low uses external
// [R5] Output enable changes only while output low
// [R6] Serial data sampled on shift clock rising
// [R7] Serial strobe high: transparent; falling: hold
// [R8] Host holds frame stable around strobe falling
// [R9] Parallel strobe low: transparent; rising: hold
// [R10] Nine-bit loop value, bit 8 is MSB
// [R11] Two-bit post code taken from parallel pins
// [R12] Diag pick field selects diag output; serial only
// [R13] Open serial pins and external reference read low
// [R14] Open parallel and control pins read high
// [R15] Parallel pins meant for power-up programming
// [R16] Frame: diag, post, loop; first bit MSB
// [R17] Most recent latching event sets configuration
`timescale 1ns/1ns
`default_nettype none
module scl_config_loader (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial port pins
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic serial_load_strobe,
    input wire logic serial_pins_driven,
    // Parallel port pins
    input wire logic parallel_load_strobe,
    input wire logic [scl_pkg::LOOP_W-1:0] loop_divider_value,
    input wire logic [scl_pkg::POST_W-1:0] post_divide_code,
    input wire logic output_enable,
    input wire logic ref_source_select,
    input wire logic parallel_pins_driven,
    // Reference and oscillator levels
    input wire logic external_reference_in,
    input wire logic ext_ref_driven,
    input wire logic crystal_pins,
    input wire logic osc_in,
    // Outputs
    output logic loop_reference,
    output scl_pkg::scl_cfg_s active_cfg,
    output logic synth_out_p,
    output logic synth_out_n,
    output logic diag_output
);
    import scl_pkg::*;

    // ==========================================================
    // Half-period count for a divide code
    function automatic logic [CNT_W-1:0] half_count(
        input logic [POST_W-1:0] code
    );
        logic [CNT_W-1:0] h;
        h = HALF_NONE;
        case (code)
            POST_DIV2: h = HALF_DIV2;
            POST_DIV4: h = HALF_DIV4;
            POST_DIV8: h = HALF_DIV8;
            default: h = HALF_NONE;
        endcase
        return h;
    endfunction : half_count

    // ==========================================================
    // Pin resolution and synchronisation
    scl_pins_s raw;
    scl_pins_s s;
    logic [PINS_W-1:0] sync_vec;

    // Undriven pins fall back to their pull level
    always_comb begin
        raw = scl_pins_s'(PINS_RST); // [R13] [R14]
        raw.xtal = crystal_pins;
        raw.osc = osc_in;
        if (serial_pins_driven) begin // [R13]
            raw.s_clk = serial_shift_clock;
            raw.s_data = serial_data_in;
            raw.s_load = serial_load_strobe;
        end
        if (parallel_pins_driven) begin // [R14]
            raw.p_load = parallel_load_strobe;
            raw.loop = loop_divider_value;
            raw.post = post_divide_code;
            raw.oe = output_enable;
            raw.ref_sel = ref_source_select;
        end
        if (ext_ref_driven) begin // [R13]
            raw.ext_ref = external_reference_in;
        end
    end

    scl_sync #(
        .WIDTH(PINS_W)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(raw ^ PINS_RST),
        .sync_out(sync_vec)
    );

    // Levels cross relative to the open bundle, so cleared sync flops
    // read as idle pins: no false strobe or load right after reset
    assign s = scl_pins_s'(sync_vec ^ PINS_RST);

    // ==========================================================
    // Edge history and serial shift register
    scl_pins_s prev_q;
    scl_pins_s prev_d;
    logic [FRAME_W-1:0] shift_q;
    logic [FRAME_W-1:0] shift_d;
    logic s_clk_rise;
    logic s_load_rise;
    logic p_load_fall;
    logic osc_rise;

    assign s_clk_rise = s.s_clk & ~prev_q.s_clk;
    assign s_load_rise = s.s_load & ~prev_q.s_load;
    assign p_load_fall = ~s.p_load & prev_q.p_load;
    assign osc_rise = s.osc & ~prev_q.osc;

    // New bits enter at the bottom, so the first one ends at the top
    always_comb begin
        prev_d = s;
        shift_d = shift_q;
        if (s_clk_rise) begin
            shift_d = {shift_q[FRAME_W-2:0], s.s_data}; // [R6] [R16]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= PINS_RST;
            shift_q <= FRAME_RST;
        end else begin
            prev_q <= prev_d;
            shift_q <= shift_d;
        end
    end

    // ==========================================================
    // Configuration latches
    scl_cfg_s cfg_q;
    scl_cfg_s cfg_d;
    scl_src_e last_src_q;
    scl_src_e last_src_d;
    logic s_transp;
    logic p_transp;
    logic use_serial;
    logic use_parallel;

    assign s_transp = s.s_load;
    assign p_transp = ~s.p_load;

    // Both open at once: the path that opened last drives the latches.
    // The host must keep the frame steady at the strobe edge, since the
    // latches follow the shift register right up to the closing edge.
    always_comb begin
        last_src_d = last_src_q;
        if (s_load_rise && !p_load_fall) begin
            last_src_d = SCL_SRC_SERIAL; // [R17]
        end else if (p_load_fall && !s_load_rise) begin
            last_src_d = SCL_SRC_PARALLEL; // [R17]
        end
        use_serial = s_transp &&
            (!p_transp || last_src_d == SCL_SRC_SERIAL); // [R17] [R8]
        use_parallel = p_transp && !use_serial;
        cfg_d = cfg_q;
        if (use_serial) begin
            cfg_d = scl_cfg_s'(shift_q); // [R7] [R12]
        end else if (use_parallel) begin
            cfg_d.loop = s.loop; // [R9] [R10] [R15]
            cfg_d.post = s.post; // [R11]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '{diag: DIAG_RST, post: POST_RST, loop: LOOP_RST};
            last_src_q <= SCL_SRC_PARALLEL;
        end else begin
            cfg_q <= cfg_d;
            last_src_q <= last_src_d;
        end
    end

    assign active_cfg = cfg_q;

    // ==========================================================
    // Output divider, synchronous enable, reference and diag mux
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] half;
    logic div_q;
    logic div_d;
    logic en_q;
    logic en_d;
    logic outp_q;
    logic outp_d;
    logic ref_q;
    logic ref_d;
    logic diag_q;
    logic diag_d;

    // The enable only moves while the divided clock is low, so a
    // change can never chop a high phase into a runt pulse.
    always_comb begin
        half = half_count(cfg_q.post);
        cnt_d = cnt_q;
        div_d = div_q;
        if (half == HALF_NONE) begin
            div_d = s.osc; // [R1] [R2]
            cnt_d = CNT_ZERO;
        end else if (osc_rise) begin
            if (cnt_q + CNT_ONE >= half) begin
                div_d = ~div_q; // [R1] [R2]
                cnt_d = CNT_ZERO;
            end else begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
        en_d = div_q ? en_q : s.oe; // [R5]
        outp_d = div_d & en_d; // [R5]
        ref_d = s.ref_sel ? s.xtal : s.ext_ref; // [R4]
        case (cfg_q.diag)
            DIAG_REF: diag_d = ref_q; // [R12]
            DIAG_OSC: diag_d = s.osc;
            DIAG_DIVOUT: diag_d = div_q;
            DIAG_SHIFT_MSB: diag_d = shift_q[FRAME_W-1];
            DIAG_LOW: diag_d = 1'b0;
            DIAG_HIGH: diag_d = 1'b1;
            DIAG_EXTREF: diag_d = s.ext_ref;
            default: diag_d = s.xtal;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= CNT_ZERO;
            div_q <= 1'b0;
            en_q <= 1'b0;
            outp_q <= 1'b0;
            ref_q <= 1'b0;
            diag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            div_q <= div_d;
            en_q <= en_d;
            outp_q <= outp_d;
            ref_q <= ref_d;
            diag_q <= diag_d;
        end
    end

    // Disabled output parks with true low and complement high
    assign synth_out_p = outp_q;
    assign synth_out_n = ~outp_q;
    assign loop_reference = ref_q;
    assign diag_output = diag_q;

    // ==========================================================
    // Checks
    a_shift_takes_bit: assert property ( // [R6] [R16]
        @(posedge clk) disable iff (!arst_n)
        s_clk_rise |=>
        shift_q == {$past(shift_q[FRAME_W-2:0]), $past(s.s_data)})
        else $error("shift register missed a serial bit");

    a_serial_follows: assert property ( // [R7]
        @(posedge clk) disable iff (!arst_n)
        (s_transp && !p_transp) |=> cfg_q == scl_cfg_s'($past(shift_q)))
        else $error("serial latch not transparent");

    a_serial_holds: assert property ( // [R7]
        @(posedge clk) disable iff (!arst_n)
        (!s_transp && !p_transp) |=> $stable(cfg_q))
        else $error("latched configuration changed while closed");

    a_parallel_follows: assert property ( // [R9] [R10] [R11]
        @(posedge clk) disable iff (!arst_n)
        (p_transp && !s_transp) |=>
        (cfg_q.loop == $past(s.loop)) && (cfg_q.post == $past(s.post)))
        else $error("parallel latch not transparent");

    a_parallel_no_diag: assert property ( // [R12]
        @(posedge clk) disable iff (!arst_n)
        !s_transp |=> $stable(cfg_q.diag))
        else $error("diag field moved without serial load");

    a_latest_wins: assert property ( // [R17]
        @(posedge clk) disable iff (!arst_n)
        (s_load_rise && p_transp && !p_load_fall) |=>
        cfg_q == scl_cfg_s'($past(shift_q)))
        else $error("newer serial load did not win");

    a_ref_choice: assert property ( // [R4]
        @(posedge clk) disable iff (!arst_n)
        ##1 loop_reference ==
        ($past(s.ref_sel) ? $past(s.xtal) : $past(s.ext_ref)))
        else $error("wrong loop reference");

    a_bypass_div: assert property ( // [R1] [R2]
        @(posedge clk) disable iff (!arst_n)
        (cfg_q.post == POST_DIV1) |=> div_q == $past(s.osc))
        else $error("divide by one does not follow oscillator");

    a_div2_toggle: assert property ( // [R1] [R2]
        @(posedge clk) disable iff (!arst_n)
        (cfg_q.post == POST_DIV2 && osc_rise) |=> div_q != $past(div_q))
        else $error("divide by two did not toggle");

    a_enable_low: assert property ( // [R5]
        @(posedge clk) disable iff (!arst_n)
        (en_q != $past(en_q)) |-> !$past(div_q))
        else $error("enable changed during high phase");

    a_disabled_quiet: assert property ( // [R5]
        @(posedge clk) disable iff (!arst_n)
        !en_q |-> ##0 !outp_q)
        else $error("output active while disabled");
endmodule : scl_config_loader
`default_nettype wire

// ==== verif/scl_host_model.sv ====
// Host model that drives the serial configuration pins.
`timescale 1ns/1ns
`default_nettype none
module scl_host_model
    import scl_pkg::*;
(
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sck,
    output logic sdo,
    output logic sld
);
    // =====
    // Pins idle low; the shift clock stands still between frames
    initial begin
        sck = 1'b0;
        sdo = 1'b0;
        sld = 1'b0;
    end

    // =====
    // One frame, first bit to the top of the frame, then the strobe
    task automatic send(input logic [FRAME_W-1:0] f);
        for (int i = FRAME_W - 1; i >= 0; i--) begin
            sdo <= f[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        // Data stays put across the strobe so the latch sees one frame
        sld <= 1'b1;
        repeat (6) @(posedge clk);
        sld <= 1'b0;
        repeat (6) @(posedge clk);
        sdo <= 1'b0; // Released line falls to its pull-down
    endtask : send
endmodule : scl_host_model
`default_nettype wire

// ==== verif/scl_config_loader_bench.sv ====
// Self-checking bench of the synthesizer configuration loader.
`timescale 1ns/1ns
`default_nettype none
module scl_config_loader_bench;
    import scl_pkg::*;
    // =====
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sck, sdo, sld, lref, sp, sn, diag;
    logic s_drv = 1'b1, p_load = 1'b1, p_drv = 1'b1, e_drv = 1'b1;
    logic [LOOP_W-1:0] loop = LOOP_RST;
    logic [POST_W-1:0] post = POST_RST;
    logic oe = 1'b1, rsel = 1'b1, ext = 1'b0, xtal = 1'b0, osc = 1'b0;
    scl_cfg_s cfg;
    scl_cfg_s cur = {DIAG_RST, POST_RST, LOOP_RST};
    int errors = 0, n_tests = 0;

    // Clock of 50 ns
    always #25 clk = ~clk;

    scl_host_model u_host (.clk(clk), .sck(sck), .sdo(sdo), .sld(sld));

    scl_config_loader u_dut (
        .clk(clk), .arst_n(arst_n),
        .serial_shift_clock(sck), .serial_data_in(sdo),
        .serial_load_strobe(sld), .serial_pins_driven(s_drv),
        .parallel_load_strobe(p_load), .loop_divider_value(loop),
        .post_divide_code(post), .output_enable(oe),
        .ref_source_select(rsel), .parallel_pins_driven(p_drv),
        .external_reference_in(ext), .ext_ref_driven(e_drv),
        .crystal_pins(xtal), .osc_in(osc), .loop_reference(lref),
        .active_cfg(cfg), .synth_out_p(sp), .synth_out_n(sn),
        .diag_output(diag)
    );

    // =====
    // Helpers; the verdict is printed only here
    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk_cfg();
        n_tests++;
        if (cfg !== cur) begin
            errors++;
            $display("unexpected at %0t: cfg %h want %h", $time, cfg, cur);
        end
    endtask : chk_cfg

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit

    // Division ratio per output code, written out independently
    function automatic int ratio(input logic [1:0] c);
        case (c)
            2'h0: return 2;
            2'h1: return 4;
            2'h2: return 8;
            default: return 1;
        endcase
    endfunction : ratio

    // What the diagnostic pin shows with static sources and divide by
    // one; code 3 sees the frame top bit, which is 0 for that code
    function automatic logic dexp(input logic [2:0] d);
        case (d)
            3'h0, 3'h7: return xtal;
            3'h1, 3'h2: return osc;
            3'h3, 3'h4: return 1'b0;
            3'h6: return ext;
            default: return 1'b1;
        endcase
    endfunction : dexp

    // Parallel load: checked while open, then held against moving pins
    task automatic par_load(input logic [8:0] l, input logic [1:0] p);
        p_load <= 1'b0;
        loop <= l;
        post <= p;
        cur.loop = l;
        cur.post = p;
        tick(6);
        @(negedge clk);
        chk_cfg();
        tick(1);
        p_load <= 1'b1;
        tick(6);
        loop <= ~l;
        post <= ~p;
        tick(6);
        @(negedge clk);
        chk_cfg();
        tick(1);
    endtask : par_load

    // =====
    // Main sequence
    initial begin
        logic last;
        int rises;
        int e;
        void'($urandom(63590));
        tick(4);
        @(negedge clk);
        chk_bit(sp, 1'b0);
        chk_bit(sn, 1'b1);
        tick(1);
        arst_n <= 1'b1;
        // Closed strobes after release: the reset configuration stands
        tick(3);
        @(negedge clk);
        chk_cfg();
        tick(1);
        // Parallel loads, corners first
        par_load(9'h000, 2'h0);
        par_load(9'h1FF, 2'h3);
        repeat (3) par_load(9'($urandom), 2'($urandom));
        // Serial frames, then a parallel load that keeps the diag pick
        repeat (3) begin
            cur = scl_cfg_s'($urandom);
            u_host.send(cur);
            @(negedge clk);
            chk_cfg();
            tick(1);
        end
        par_load(9'($urandom), 2'($urandom));
        // Divider per code; pass 4 repeats code 3 with the output off
        for (int c = 0; c < 5; c++) begin
            par_load(cur.loop, c[1:0] | {2{c[2]}});
            oe <= !c[2];
            rises = 0;
            last = 1'b1;
            for (int k = 0; k < 544; k++) begin
                osc <= k[3]; // One fixed legal oscillator rate
                @(negedge clk);
                chk_bit(sn, ~sp);
                if (k >= 32 && sp === 1'b1 && last === 1'b0) begin
                    rises++;
                end
                last = sp;
                @(posedge clk);
            end
            e = c[2] ? 0 : 32 / ratio(c[1:0]);
            chk_bit((rises - e) * (rises - e) <= 1, 1'b1);
        end
        oe <= 1'b1;
        // Reference choice over all select and level pairs
        for (int k = 0; k < 4; k++) begin
            rsel <= k[0];
            xtal <= k[1];
            ext <= ~k[1];
            tick(5);
            @(negedge clk);
            chk_bit(lref, k[0] ? k[1] : ~k[1]);
            tick(1);
        end
        // Open parallel pins read high: crystal chosen, latches hold
        p_drv <= 1'b0;
        rsel <= 1'b0;
        tick(6);
        @(negedge clk);
        chk_bit(lref, 1'b1);
        chk_cfg();
        tick(1);
        // Open serial pins and reference read low
        p_drv <= 1'b1;
        e_drv <= 1'b0;
        ext <= 1'b1;
        s_drv <= 1'b0;
        u_host.send(14'($urandom));
        @(negedge clk);
        chk_bit(lref, 1'b0);
        chk_cfg();
        tick(1);
        s_drv <= 1'b1;
        e_drv <= 1'b1;
        rsel <= 1'b1;
        ext <= 1'($urandom);
        xtal <= 1'($urandom);
        // Every diagnostic pick with static sources; divide by one lets
        // the divided clock stand at the oscillator level
        for (int i = 0; i < 8; i++) begin
            cur = scl_cfg_s'($urandom);
            cur.diag = 3'(i);
            cur.post = 2'h3;
            u_host.send(cur);
            tick(4);
            @(negedge clk);
            chk_bit(diag, dexp(cur.diag));
            tick(1);
        end
        end_of_test();
    end
endmodule : scl_config_loader_bench
`default_nettype wire
